// ---- rtl/iox_exec.sv ----
// execution datapath: increment, skip-increment, or, left shift and absolute jump
//
// Function
// - file operations use 7-bit address; dest 0 writes accumulator, 1 writes register
// - skip-increment adds one, flags untouched, zero result flushes next instruction
// - plain increment adds one, stores per dest, updates zero flag
// - jump loads 11-bit immediate into program counter bits 10..0
// - jump fills program counter bits 14..11 from latch bits 6..3
// - jump is unconditional and takes two instruction cycles
// - or-literal ors accumulator with 8-bit literal into accumulator, updates zero
// - or-register ors accumulator with register, stores per dest, updates zero
// - left shift: bit7 to carry, bits 6..0 to 7..1, zero in, updates C,Z
`timescale 1ns/1ps
module iox_exec
	import iox_pkg::*;
(
	// clock and reset
	input  wire logic                clk_in,
	input  wire logic                rst_in,
	// instruction issue
	input  wire logic                valid_in,
	input  wire iox_op_t             op_in,
	input  wire logic [FADDR_W-1:0]  faddr_in,
	input  wire logic                dest_in,
	input  wire logic [DATA_W-1:0]   lit_in,
	input  wire logic [JUMP_K_W-1:0] jump_k_in,
	// file register read port and upper latch
	input  wire logic [DATA_W-1:0]   file_rdata_in,
	input  wire logic [LATCH_W-1:0]  upper_latch_in,
	// file register write port
	output logic                     file_we_out,
	output logic [FADDR_W-1:0]       file_addr_out,
	output logic [DATA_W-1:0]        file_wdata_out,
	// architectural state
	output logic [DATA_W-1:0]        acc_out,
	output logic                     zero_out,
	output logic                     carry_out,
	output logic [PC_W-1:0]          pc_out,
	output logic                     pc_load_out,
	// issue control
	output logic                     ready_out,
	output logic                     flush_out
);

	iox_state_t        state_r;
	iox_state_t        state_nxt;
	logic [DATA_W-1:0] acc_r;
	logic              zero_r;
	logic              carry_r;
	logic [PC_W-1:0]   pc_r;
	logic              pc_load_r;
	logic              file_we_r;
	logic [FADDR_W-1:0] file_addr_r;
	logic [DATA_W-1:0] file_wdata_r;

	logic [DATA_W-1:0] alu_res;
	logic              alu_zero;
	logic              alu_carry;
	logic              alu_zero_we;
	logic              alu_carry_we;
	logic              alu_writes;

	iox_alu u_alu (
		.op_in        (op_in),
		.acc_in       (acc_r),
		.file_in      (file_rdata_in),
		.lit_in       (lit_in),
		.result_out   (alu_res),
		.zero_out     (alu_zero),
		.carry_out    (alu_carry),
		.zero_we_out  (alu_zero_we),
		.carry_we_out (alu_carry_we),
		.writes_out   (alu_writes)
	);

	// issue is accepted only in the execute state; the flush slot stands in for a nop
	wire take      = valid_in && (state_r == IOX_ST_EXEC);
	wire do_write  = take && alu_writes;
	// or-literal always targets the accumulator regardless of dest
	wire to_file   = (op_in != IOX_OP_ORL) && (dest_in == DEST_FILE);
	wire acc_we    = do_write && !to_file;
	wire file_we   = do_write && to_file;
	wire skip_hit  = take && (op_in == IOX_OP_INCS) && (alu_res == 8'h00);
	wire jump_hit  = take && (op_in == IOX_OP_JMP);
	wire [PC_W-1:0] jump_pc = {upper_latch_in[LATCH_SEL_HI:LATCH_SEL_LO], jump_k_in};

	// second cycle of skip or jump is a discarded slot
	always_comb begin
		case (state_r)
			IOX_ST_EXEC:  state_nxt = (skip_hit || jump_hit) ? IOX_ST_FLUSH : IOX_ST_EXEC;
			IOX_ST_FLUSH: state_nxt = IOX_ST_EXEC;
			default:      state_nxt = IOX_ST_EXEC;
		endcase
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_r <= IOX_ST_EXEC;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			acc_r   <= ACC_RST;
			zero_r  <= ZERO_RST;
			carry_r <= CARRY_RST;
		end else begin
			if (acc_we) begin
				acc_r <= alu_res;
			end
			if (take && alu_zero_we) begin
				zero_r <= alu_zero;
			end
			if (take && alu_carry_we) begin
				carry_r <= alu_carry;
			end
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			file_we_r    <= 1'b0;
			file_addr_r  <= 7'h00;
			file_wdata_r <= 8'h00;
		end else begin
			file_we_r <= file_we;
			if (file_we) begin
				file_addr_r  <= faddr_in;
				file_wdata_r <= alu_res;
			end
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			pc_r      <= PC_RST;
			pc_load_r <= 1'b0;
		end else begin
			pc_load_r <= jump_hit;
			if (jump_hit) begin
				pc_r <= jump_pc;
			end
		end
	end

	assign ready_out      = (state_r == IOX_ST_EXEC);
	assign flush_out      = (state_r == IOX_ST_FLUSH);
	assign acc_out        = acc_r;
	assign zero_out       = zero_r;
	assign carry_out      = carry_r;
	assign pc_out         = pc_r;
	assign pc_load_out    = pc_load_r;
	assign file_we_out    = file_we_r;
	assign file_addr_out  = file_addr_r;
	assign file_wdata_out = file_wdata_r;

endmodule : iox_exec

// ---- pkg/iox_pkg.sv ----
// shared constants and types for the increment/or/shift/jump execution datapath
package iox_pkg;

	localparam int DATA_W    = 8;
	localparam int FADDR_W   = 7;
	localparam int PC_W      = 15;
	localparam int JUMP_K_W  = 11;
	localparam int LATCH_W   = 7;

	// jump target split
	localparam int PC_LOW_HI    = 10;
	localparam int PC_HIGH_LO   = 11;
	localparam int PC_HIGH_HI   = 14;
	localparam int LATCH_SEL_LO = 3;
	localparam int LATCH_SEL_HI = 6;

	// destination select encodings
	localparam logic DEST_ACC  = 1'b0;
	localparam logic DEST_FILE = 1'b1;

	// reset values
	localparam logic [DATA_W-1:0]  ACC_RST   = 8'h00;
	localparam logic [PC_W-1:0]    PC_RST    = 15'h0000;
	localparam logic               ZERO_RST  = 1'b0;
	localparam logic               CARRY_RST = 1'b0;

	// instruction cycle counts
	localparam int ONE_CYCLE = 1;
	localparam int TWO_CYCLE = 2;

	typedef enum logic [2:0] {
		IOX_OP_NONE = 3'h0,
		IOX_OP_INCS = 3'h1,
		IOX_OP_INC  = 3'h2,
		IOX_OP_JMP  = 3'h3,
		IOX_OP_ORL  = 3'h4,
		IOX_OP_ORF  = 3'h5,
		IOX_OP_SHL  = 3'h6
	} iox_op_t;

	typedef enum logic [1:0] {
		IOX_ST_EXEC  = 2'b01,
		IOX_ST_FLUSH = 2'b10
	} iox_state_t;

endpackage : iox_pkg

// ---- rtl/iox_alu.sv ----
// combinational result and flag generation for the supported operations
`timescale 1ns/1ps
module iox_alu
	import iox_pkg::*;
(
	// operation and operands
	input  wire iox_op_t           op_in,
	input  wire logic [DATA_W-1:0] acc_in,
	input  wire logic [DATA_W-1:0] file_in,
	input  wire logic [DATA_W-1:0] lit_in,
	// result and flags
	output logic [DATA_W-1:0]      result_out,
	output logic                   zero_out,
	output logic                   carry_out,
	output logic                   zero_we_out,
	output logic                   carry_we_out,
	output logic                   writes_out
);

	wire [DATA_W-1:0] inc_val = file_in + 8'h01;
	wire [DATA_W-1:0] orl_val = acc_in | lit_in;
	wire [DATA_W-1:0] orf_val = acc_in | file_in;
	wire [DATA_W-1:0] shl_val = {file_in[DATA_W-2:0], 1'b0};

	assign result_out   = (op_in == IOX_OP_INCS || op_in == IOX_OP_INC) ? inc_val :
	                      (op_in == IOX_OP_ORL) ? orl_val :
	                      (op_in == IOX_OP_ORF) ? orf_val :
	                      (op_in == IOX_OP_SHL) ? shl_val : 8'h00;
	assign zero_out     = (result_out == 8'h00);
	assign carry_out    = file_in[DATA_W-1];
	// skip-increment leaves every flag alone
	assign zero_we_out  = (op_in == IOX_OP_INC) || (op_in == IOX_OP_ORL) ||
	                      (op_in == IOX_OP_ORF) || (op_in == IOX_OP_SHL);
	assign carry_we_out = (op_in == IOX_OP_SHL);
	assign writes_out   = (op_in != IOX_OP_NONE) && (op_in != IOX_OP_JMP);

endmodule : iox_alu

// ---- verif/iox_exec_sva.sv ----
// concurrent checks on the execution datapath ports
`timescale 1ns/1ps
module iox_exec_sva
	import iox_pkg::*;
(
	input wire logic clk_in, rst_in, valid_in, dest_in, ready_out, flush_out,
	input wire iox_op_t op_in,
	input wire logic [DATA_W-1:0] file_rdata_in, lit_in, acc_out, file_wdata_out,
	input wire logic zero_out, carry_out, pc_load_out, file_we_out,
	input wire logic [JUMP_K_W-1:0] jump_k_in,
	input wire logic [LATCH_W-1:0] upper_latch_in,
	input wire logic [PC_W-1:0] pc_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	wire take_w = valid_in && ready_out;
	wire jmp_w = take_w && op_in == IOX_OP_JMP;
	property p_jlo; jmp_w |=> pc_load_out && pc_out[10:0] == $past(jump_k_in); endproperty
	a_jlo: assert property (p_jlo) else $error("jump low bits");
	property p_jhi; jmp_w |=> pc_out[14:11] == $past(upper_latch_in[6:3]); endproperty
	a_jhi: assert property (p_jhi) else $error("jump high bits");
	property p_jfl; jmp_w |=> flush_out ##1 ready_out; endproperty
	a_jfl: assert property (p_jfl) else $error("jump cycles");
	property p_skp; take_w && op_in == IOX_OP_INCS && file_rdata_in == 8'hff |=> flush_out;
	endproperty
	a_skp: assert property (p_skp) else $error("skip slot");
	property p_sfl; take_w && op_in == IOX_OP_INCS |=> $stable(zero_out) && $stable(carry_out);
	endproperty
	a_sfl: assert property (p_sfl) else $error("skip flags");
	property p_inc; take_w && op_in == IOX_OP_INC && dest_in
		|=> file_we_out && file_wdata_out == $past(file_rdata_in) + 8'h01; endproperty
	a_inc: assert property (p_inc) else $error("increment");
	property p_shl; take_w && op_in == IOX_OP_SHL |=> carry_out == $past(file_rdata_in[7])
		&& zero_out == ($past(file_rdata_in[6:0]) == 7'h00); endproperty
	a_shl: assert property (p_shl) else $error("shift");
	property p_sha; take_w && op_in == IOX_OP_SHL && !dest_in
		|=> acc_out == {$past(file_rdata_in[6:0]), 1'b0}; endproperty
	a_sha: assert property (p_sha) else $error("shift result");
	property p_orl; take_w && op_in == IOX_OP_ORL
		|=> acc_out == ($past(acc_out) | $past(lit_in)) && zero_out == (acc_out == 8'h00);
	endproperty
	a_orl: assert property (p_orl) else $error("or literal");
	property p_orf; take_w && op_in == IOX_OP_ORF && !dest_in
		|=> acc_out == ($past(acc_out) | $past(file_rdata_in)); endproperty
	a_orf: assert property (p_orf) else $error("or register");
	property p_one; take_w && op_in inside {IOX_OP_INC, IOX_OP_ORL, IOX_OP_ORF, IOX_OP_SHL}
		|=> ready_out; endproperty
	a_one: assert property (p_one) else $error("single cycle");
	c_jmp: cover property (jmp_w);
	c_skp: cover property (take_w && op_in == IOX_OP_INCS ##1 flush_out);
	c_shl: cover property (take_w && op_in == IOX_OP_SHL ##1 carry_out);
endmodule : iox_exec_sva
bind iox_exec iox_exec_sva u_sva (.*);

// ---- verif/incr_or_shift_jump_absolute_exec_tb_top.sv ----
// self-checking bench for the execution datapath
`timescale 1ns/1ps
module incr_or_shift_jump_absolute_exec_tb_top;
	import iox_pkg::*;
	logic clk_in = 0, rst_in = 1, valid_in = 0, dest_in = 0;
	iox_op_t op_in = IOX_OP_NONE;
	logic [FADDR_W-1:0] faddr_in = 7'h7f;
	logic [DATA_W-1:0] lit_in = 8'h00, file_rdata_in = 8'h00;
	logic [JUMP_K_W-1:0] jump_k_in = 11'h7ff;
	logic [LATCH_W-1:0] upper_latch_in = 7'h48;
	logic file_we_out, zero_out, carry_out, pc_load_out, ready_out, flush_out;
	logic [FADDR_W-1:0] file_addr_out;
	logic [DATA_W-1:0] file_wdata_out, acc_out;
	logic [PC_W-1:0] pc_out;
	int miscompares = 0, tests_run = 0, cycles = 0;
	iox_exec u_dut (.*);
	initial forever #4 clk_in = ~clk_in;
	// generous ceiling; the whole sequence needs about 30 cycles
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 2000) begin
			miscompares++;
			conclude();
		end
	end
	task chk(input string n, input logic [15:0] e, g);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// one instruction slot, returns in the cycle after it is taken
	task go(input iox_op_t o, input logic d, input logic [7:0] rd, l);
		@(negedge clk_in);
		valid_in = 1;
		op_in = o;
		dest_in = d;
		file_rdata_in = rd;
		lit_in = l;
		@(negedge clk_in);
		valid_in = 0;
	endtask : go
	task t_inc;
		go(IOX_OP_INC, DEST_ACC, 8'h3f, 8'h00);
		chk("acc", 8'h40, acc_out);
		chk("we", 0, file_we_out);
		chk("zero", 0, zero_out);
		go(IOX_OP_INC, DEST_FILE, 8'hff, 8'h00);
		chk("we", 1, file_we_out);
		chk("addr", 7'h7f, file_addr_out);
		chk("wdata", 8'h00, file_wdata_out);
		chk("zero", 1, zero_out);
		chk("acc", 8'h40, acc_out);
		$display("increment done");
	endtask : t_inc
	task t_incs;
		@(negedge clk_in);
		valid_in = 1;
		op_in = IOX_OP_INCS;
		dest_in = DEST_ACC;
		file_rdata_in = 8'hff;
		@(negedge clk_in);
		chk("acc", 8'h00, acc_out);
		chk("zero", 1, zero_out);
		chk("flush", 1, flush_out);
		chk("ready", 0, ready_out);
		// offered in the discarded slot, so it must leave no trace
		op_in = IOX_OP_INC;
		file_rdata_in = 8'h05;
		@(negedge clk_in);
		valid_in = 0;
		chk("acc nop", 8'h00, acc_out);
		chk("zero nop", 1, zero_out);
		go(IOX_OP_INCS, DEST_ACC, 8'h03, 8'h00);
		chk("acc", 8'h04, acc_out);
		chk("zero", 1, zero_out);
		chk("flush", 0, flush_out);
		$display("skip increment done");
	endtask : t_incs
	task t_or;
		go(IOX_OP_ORL, DEST_FILE, 8'h00, 8'h10);
		chk("acc", 8'h14, acc_out);
		chk("zero", 0, zero_out);
		chk("we", 0, file_we_out);
		go(IOX_OP_ORF, DEST_ACC, 8'h41, 8'h00);
		chk("acc", 8'h55, acc_out);
		go(IOX_OP_ORF, DEST_FILE, 8'h2a, 8'h00);
		chk("wdata", 8'h7f, file_wdata_out);
		chk("acc", 8'h55, acc_out);
		$display("or done");
	endtask : t_or
	task t_shl;
		go(IOX_OP_SHL, DEST_ACC, 8'h80, 8'h00);
		chk("acc", 8'h00, acc_out);
		chk("carry", 1, carry_out);
		chk("zero", 1, zero_out);
		go(IOX_OP_SHL, DEST_FILE, 8'h55, 8'h00);
		chk("we", 1, file_we_out);
		chk("wdata", 8'haa, file_wdata_out);
		chk("carry", 0, carry_out);
		chk("zero", 0, zero_out);
		chk("acc", 8'h00, acc_out);
		$display("shift done");
	endtask : t_shl
	task t_jmp;
		go(IOX_OP_JMP, DEST_ACC, 8'h00, 8'h00);
		chk("pc", 15'h4fff, pc_out);
		chk("load", 1, pc_load_out);
		chk("flush", 1, flush_out);
		@(negedge clk_in);
		chk("ready", 1, ready_out);
		$display("jump done");
	endtask : t_jmp
	task conclude;
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : conclude
	initial begin
		repeat (4) @(negedge clk_in);
		rst_in = 0;
		t_inc();
		t_incs();
		t_or();
		t_shl();
		t_jmp();
		conclude();
	end
endmodule : incr_or_shift_jump_absolute_exec_tb_top
